// file: uvd_pkg.sv
// Purpose: shared constants and types for the undervoltage detector control
// Assumes: 50 MHz system clock, AXI4-Lite register access
// Notes:   register indices are word indices; byte address is four times index
package uvd_pkg;

    // ------------------------------------------------------------
    // register indices and bus
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W          = 6;
    localparam logic [3:0]  IDX_MODE_CTRL   = 4'h0;  // detector_mode_control
    localparam logic [3:0]  IDX_THRESH_CTRL = 4'h1;  // detector_threshold_control
    localparam logic [3:0]  IDX_RSVD_FIRST  = 4'h2;
    localparam logic [3:0]  IDX_RSVD_LAST   = 4'h7;
    localparam logic [3:0]  IDX_MARGIN_CTRL = 4'h8;  // warning_margin_control
    localparam logic [3:0]  IDX_IRQ_CTRL    = 4'h9;  // warning_irq_control
    localparam logic [3:0]  IDX_IRQ_FLAGS   = 4'hA;  // warning_irq_flags
    localparam logic [3:0]  IDX_LEVEL_STAT  = 4'hB;  // warning_level_status
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int unsigned POS_SLEEP_MODE  = 0;  // bits 1:0 of mode control
    localparam int unsigned POS_AWAKE_MODE  = 2;  // bits 3:2
    localparam int unsigned POS_SAMPLE_RATE = 4;  // bit 4
    localparam int unsigned POS_IRQ_ENABLE  = 0;  // irq control bit 0
    localparam int unsigned POS_DIRECTION   = 1;  // irq control bits 2:1
    // detector fuse byte layout
    localparam int unsigned FUSE_THRESH     = 0;  // bits 2:0
    localparam int unsigned FUSE_RATE       = 3;  // bit 3
    localparam int unsigned FUSE_AWAKE      = 4;  // bits 5:4
    localparam int unsigned FUSE_SLEEP      = 6;  // bits 7:6

    // ------------------------------------------------------------
    // encodings and reset values
    // ------------------------------------------------------------
    localparam logic [1:0] MODE_DISABLED   = 2'h0;
    localparam logic [1:0] MODE_CONTINUOUS = 2'h1;
    localparam logic [1:0] MODE_SAMPLED    = 2'h2;
    localparam logic [1:0] MODE_WAKE_HOLD  = 2'h3;  // continuous_with_wake_hold
    localparam logic [1:0] DIR_FALL        = 2'h0;
    localparam logic [1:0] DIR_RISE        = 2'h1;
    localparam logic [1:0] DIR_CROSS       = 2'h2;
    localparam logic [1:0] MARGIN_RESET    = 2'h0;
    localparam logic [2:0] IRQ_CTRL_RESET  = 3'h0;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ         = 50_000_000;
    localparam int unsigned RATE_FAST_HZ   = 1000;
    localparam int unsigned RATE_SLOW_HZ   = 125;
    localparam int unsigned FAST_CYCLES    = CLK_HZ / RATE_FAST_HZ;
    localparam int unsigned SLOW_CYCLES    = CLK_HZ / RATE_SLOW_HZ;

    // drive toward the analog comparators
    typedef struct packed {
        logic       detector_enable;
        logic       sample_strobe;
        logic [2:0] threshold_code;
        logic [1:0] margin_select;
        logic       monitor_enable;
    } detector_drive_s;

endpackage

// file: undervoltage_detector_control.sv
// Purpose: undervoltage detector mode control and supply warning monitor
// Assumes: all inputs synchronous to aclk; fuse byte stable during reset
// Notes:   AXI4-Lite slave, byte address = 4 * register index
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// - during reset load threshold, sample rate, awake and sleep modes from fuse byte
// - threshold and awake mode read-only; only sleep mode rewritable
// - irq enable bit enables warning monitor; direction field selects trigger
// - monitor follows detector mode; inactive while detector disabled
// - in sampled mode monitor evaluates only at sample instants
// - with irq enabled, set flag on crossing in selected direction
// - warning interrupt withheld while processor halted in debug
// - request asserted while enable and flag both set, until flag cleared
// - deep sleep uses sleep mode; waking returns to awake mode
// - sleep-mode write without valid unlock is ignored
// - sample rate bit 4: 0 gives 1 kHz, 1 gives 125 Hz, read-only
// - awake mode bits 3:2: disabled, continuous, sampled, continuous with wake hold
// - sleep mode bits 1:0: disabled, continuous, sampled, 3 reserved
// - threshold code bits 2:0 read-only, upper bits read zero
// - margin bits 1:0 select 5, 15 or 25 percent above threshold
// - direction: 0 falls below, 1 rises above, 2 either, 3 reserved
// - flag set only while detector enabled, otherwise held; clearing by write works in any mode
// - status reads 1 below warning threshold, valid while detector enabled
module undervoltage_detector_control #(
    parameter int unsigned FAST_PERIOD = uvd_pkg::FAST_CYCLES,
    parameter int unsigned SLOW_PERIOD = uvd_pkg::SLOW_CYCLES
) (
    // clock and reset
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    // axi4-lite write address, data and response
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [uvd_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    output logic [1:0]                  s_axi_bresp,
    // axi4-lite read
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    input  wire logic [uvd_pkg::ADDR_W-1:0] s_axi_araddr,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    // fuse loader and processor status
    input  wire logic [7:0]             detector_fuse_byte,
    input  wire logic                   config_change_lock,
    input  wire logic                   deep_sleep,
    input  wire logic                   debug_halt,
    // analog comparators
    input  wire logic                   detector_running,
    input  wire logic                   supply_below_warning,
    output uvd_pkg::detector_drive_s    detector_drive,
    // processor side
    output logic                        execution_hold,
    output logic                        warning_irq
);
    import uvd_pkg::*;

    localparam int unsigned CNT_W = $clog2(SLOW_PERIOD + 1);

    // ------------------------------------------------------------
    // elaboration check
    // ------------------------------------------------------------
    if (FAST_PERIOD < 2 || SLOW_PERIOD < FAST_PERIOD) begin : g_bad_period
        $error("sample periods must be at least 2 and slow not below fast");
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic              aw_held;
        logic [3:0]        aw_index;
        logic              aw_bad;
        logic              w_held;
        logic [7:0]        w_data;
        logic              w_lane0;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              rvalid;
        logic [7:0]        rdata;
        logic [1:0]        rresp;
        logic [2:0]        threshold_code;
        logic              sample_rate_select;
        logic [1:0]        awake_mode;
        logic [1:0]        sleep_mode;
        logic [1:0]        warning_margin_select;
        logic [1:0]        warning_direction_select;
        logic              warning_irq_enable;
        logic              warning_irq_flag;
        logic              warning_below_status;
        logic              level_valid;
        logic [CNT_W-1:0]  div_count;
        logic              strobe;
        logic              deep_q;
        logic              wake_hold;
    } state_s;

    state_s     state;
    state_s     next_state;
    logic [1:0] eff_mode;
    logic       det_enabled;
    logic       sampled;
    logic       evaluate;
    logic       do_write;
    logic       do_read;
    logic       flag_clear;
    logic       cross_fall;
    logic       cross_rise;
    logic       trigger;
    logic [CNT_W-1:0] period_last;

    // operating mode: deep sleep picks sleep field, else awake field
    always_comb begin
        eff_mode = state.deep_q ? state.sleep_mode : state.awake_mode;
        if (eff_mode == MODE_WAKE_HOLD) begin
            eff_mode = state.deep_q ? MODE_DISABLED : MODE_CONTINUOUS;
        end
    end

    // monitor gating and crossing detection
    assign det_enabled = (eff_mode != MODE_DISABLED);
    assign sampled     = (eff_mode == MODE_SAMPLED);
    assign evaluate    = det_enabled && (!sampled || state.strobe);
    assign cross_fall  = supply_below_warning && !state.warning_below_status;
    assign cross_rise  = !supply_below_warning && state.warning_below_status;
    assign period_last = state.sample_rate_select ? CNT_W'(SLOW_PERIOD - 1)
                                                  : CNT_W'(FAST_PERIOD - 1);

    // direction select; reserved code never triggers
    always_comb begin
        case (state.warning_direction_select)
            DIR_FALL:  trigger = cross_fall;
            DIR_RISE:  trigger = cross_rise;
            DIR_CROSS: trigger = cross_fall || cross_rise;
            default:   trigger = 1'b0;
        endcase
        trigger = trigger && evaluate && state.level_valid && state.warning_irq_enable;
    end

    // bus handshake terms
    assign do_write   = state.aw_held && state.w_held && !state.bvalid;
    assign do_read    = s_axi_arvalid && !state.rvalid;
    assign flag_clear = do_write && !state.aw_bad && state.w_lane0 && state.aw_index == IDX_IRQ_FLAGS
                        && state.w_data[0];

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        // write channels taken in either order
        if (s_axi_awvalid && !state.aw_held) begin
            next_state.aw_held  = 1'b1;
            next_state.aw_index = s_axi_awaddr[5:2];
            next_state.aw_bad   = (s_axi_awaddr[5:2] > IDX_LEVEL_STAT);
        end
        if (s_axi_wvalid && !state.w_held) begin
            next_state.w_held  = 1'b1;
            next_state.w_data  = s_axi_wdata[7:0];
            next_state.w_lane0 = s_axi_wstrb[0];
        end
        if (state.bvalid && s_axi_bready) begin
            next_state.bvalid = 1'b0;
        end
        if (do_write) begin
            next_state.aw_held = 1'b0;
            next_state.w_held  = 1'b0;
            next_state.bvalid  = 1'b1;
            next_state.bresp   = state.aw_bad ? RESP_SLVERR : RESP_OKAY;
            if (state.w_lane0 && !state.aw_bad) begin
                case (state.aw_index)
                    IDX_MODE_CTRL: begin
                        if (config_change_lock) begin
                            next_state.sleep_mode = state.w_data[POS_SLEEP_MODE +: 2];
                        end
                    end
                    IDX_MARGIN_CTRL: begin
                        next_state.warning_margin_select = state.w_data[1:0];
                    end
                    IDX_IRQ_CTRL: begin
                        next_state.warning_irq_enable       = state.w_data[POS_IRQ_ENABLE];
                        next_state.warning_direction_select = state.w_data[POS_DIRECTION +: 2];
                    end
                    default: begin
                        next_state.aw_held = 1'b0;  // read-only and reserved: ignored
                    end
                endcase
            end
        end
        // read answer one cycle after address
        if (state.rvalid && s_axi_rready) begin
            next_state.rvalid = 1'b0;
        end
        if (do_read) begin
            next_state.rvalid = 1'b1;
            next_state.rdata  = 8'h00;
            next_state.rresp  = (s_axi_araddr[5:2] > IDX_LEVEL_STAT) ? RESP_SLVERR : RESP_OKAY;
            case (s_axi_araddr[5:2])
                IDX_MODE_CTRL:   next_state.rdata = {3'h0, state.sample_rate_select,
                                                     state.awake_mode, state.sleep_mode};
                IDX_THRESH_CTRL: next_state.rdata = {5'h00, state.threshold_code};
                IDX_MARGIN_CTRL: next_state.rdata = {6'h00, state.warning_margin_select};
                IDX_IRQ_CTRL:    next_state.rdata = {5'h00, state.warning_direction_select,
                                                     state.warning_irq_enable};
                IDX_IRQ_FLAGS:   next_state.rdata = {7'h00, state.warning_irq_flag};
                IDX_LEVEL_STAT:  next_state.rdata = {7'h00, state.warning_below_status};
                default:         next_state.rdata = 8'h00;
            endcase
        end
        // sample-instant divider
        next_state.strobe = 1'b0;
        if (!det_enabled || !sampled) begin
            next_state.div_count = '0;
        end else if (state.div_count >= period_last) begin
            next_state.div_count = '0;
            next_state.strobe    = 1'b1;
        end else begin
            next_state.div_count = state.div_count + CNT_W'(1);
        end
        // comparator level and validity
        if (!det_enabled) begin
            next_state.level_valid = 1'b0;
        end else if (evaluate) begin
            next_state.warning_below_status = supply_below_warning;
            next_state.level_valid          = 1'b1;
        end
        // flag: set wins over clear, set only while enabled
        if (flag_clear) begin
            next_state.warning_irq_flag = 1'b0;
        end
        if (trigger) begin
            next_state.warning_irq_flag = 1'b1;
        end
        // sleep tracking and wake hold
        next_state.deep_q = deep_sleep;
        if (state.deep_q && !deep_sleep && state.awake_mode == MODE_WAKE_HOLD) begin
            next_state.wake_hold = 1'b1;
        end else if (detector_running || deep_sleep) begin
            next_state.wake_hold = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // registers; fuse byte loaded while reset is held
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state                          <= '0;
            state.threshold_code           <= detector_fuse_byte[FUSE_THRESH +: 3];
            state.sample_rate_select       <= detector_fuse_byte[FUSE_RATE];
            state.awake_mode               <= detector_fuse_byte[FUSE_AWAKE +: 2];
            state.sleep_mode               <= detector_fuse_byte[FUSE_SLEEP +: 2];
            state.warning_margin_select    <= MARGIN_RESET;
            state.warning_direction_select <= IRQ_CTRL_RESET[2:1];
            state.warning_irq_enable       <= IRQ_CTRL_RESET[0];
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign s_axi_awready = !state.aw_held;
    assign s_axi_wready  = !state.w_held;
    assign s_axi_bvalid  = state.bvalid;
    assign s_axi_bresp   = state.bresp;
    assign s_axi_arready = !state.rvalid;
    assign s_axi_rvalid  = state.rvalid;
    assign s_axi_rdata   = {24'h000000, state.rdata};
    assign s_axi_rresp   = state.rresp;

    // analog drive and interrupt
    assign detector_drive = '{
        detector_enable: det_enabled,
        sample_strobe:   state.strobe,
        threshold_code:  state.threshold_code,
        margin_select:   state.warning_margin_select,
        monitor_enable:  det_enabled && state.warning_irq_enable
    };
    assign execution_hold = state.wake_hold;
    assign warning_irq    = state.warning_irq_enable && state.warning_irq_flag && !debug_halt;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_irq_debug_block: assert property (@(posedge aclk) disable iff (!aresetn)
        debug_halt |-> !warning_irq) else $error("irq raised during debug halt");
    a_irq_flag_enable: assert property (@(posedge aclk) disable iff (!aresetn)
        (state.warning_irq_flag && state.warning_irq_enable && !debug_halt) |-> warning_irq)
        else $error("irq missing with flag and enable set");
    a_awake_read_only: assert property (@(posedge aclk) disable iff (!aresetn)
        ##1 ($stable(state.awake_mode) && $stable(state.threshold_code)))
        else $error("read-only fuse field changed");
    a_sleep_locked: assert property (@(posedge aclk) disable iff (!aresetn)
        (do_write && state.aw_index == IDX_MODE_CTRL && !config_change_lock) |=> $stable(state.sleep_mode))
        else $error("sleep mode changed without unlock");
    a_monitor_off: assert property (@(posedge aclk) disable iff (!aresetn)
        (eff_mode == MODE_DISABLED) |-> !detector_drive.monitor_enable)
        else $error("monitor active while detector disabled");
    a_sampled_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        (sampled && !state.strobe) |=> $stable(state.warning_below_status))
        else $error("status moved between sample instants");
    a_flag_held_off: assert property (@(posedge aclk) disable iff (!aresetn)
        (!det_enabled && !state.warning_irq_flag) |=> !state.warning_irq_flag)
        else $error("flag set while detector disabled");
    a_sleep_mode_use: assert property (@(posedge aclk) disable iff (!aresetn)
        (state.deep_q && state.sleep_mode == MODE_SAMPLED) |-> sampled)
        else $error("deep sleep not using sleep mode");
    a_reserved_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        (do_read && s_axi_araddr[5:2] >= IDX_RSVD_FIRST && s_axi_araddr[5:2] <= IDX_RSVD_LAST)
        |=> (s_axi_rvalid && s_axi_rdata == 32'h00000000 && s_axi_rresp == RESP_OKAY))
        else $error("reserved offset read not zero");
    a_flag_clear: assert property (@(posedge aclk) disable iff (!aresetn)
        (flag_clear && !trigger) |=> !state.warning_irq_flag) else $error("flag not cleared");
    // flag set, request gating, wake hold and reserved writes
    a_trigger_sets_flag: assert property (@(posedge aclk) disable iff (!aresetn)
        trigger |=> state.warning_irq_flag) else $error("flag not set on warning crossing");
    a_irq_enable_gate: assert property (@(posedge aclk) disable iff (!aresetn)
        !state.warning_irq_enable |-> !warning_irq) else $error("irq raised while disabled");
    a_wake_hold_set: assert property (@(posedge aclk) disable iff (!aresetn)
        (state.deep_q && !deep_sleep && state.awake_mode == MODE_WAKE_HOLD) |=> execution_hold)
        else $error("execution not held after wake");
    a_reserved_write: assert property (@(posedge aclk) disable iff (!aresetn)
        (do_write && state.aw_index >= IDX_RSVD_FIRST && state.aw_index <= IDX_RSVD_LAST)
        |=> ($stable(state.sleep_mode) && $stable(state.warning_margin_select)
        && $stable(state.warning_irq_enable) && $stable(state.warning_direction_select)))
        else $error("reserved write changed a register");

endmodule
`default_nettype wire

// file: analog_partner.sv
// Purpose: behavioural comparators and fuse loader beside the detector control
// Assumes: driven from the bench clock domain
// Notes:   comparator output is scrambled while the monitor is unpowered
`timescale 1ns/100ps
`default_nettype none
module analog_partner (
    // clock and drive from the control block
    input  wire logic                    aclk,
    input  wire uvd_pkg::detector_drive_s drive,
    // bench controls
    input  wire logic                    supply_low,
    input  wire logic [7:0]              fuse_in,
    // answers to the control block
    output logic                         running,
    output logic                         below,
    output logic [7:0]                   fuse_byte
);
    import uvd_pkg::*;
    // ----------------------------------------
    // start-up delay and junk pattern
    // ----------------------------------------
    logic [1:0] settle = 2'h0;
    logic       junk   = 1'b0;
    // detector settles a few cycles after enable
    always @(posedge aclk) begin
        if (!drive.detector_enable) settle <= 2'h0;
        else if (settle != 2'h3) settle <= settle + 2'h1;
        junk <= ~junk;
    end
    assign running   = (settle == 2'h3);
    assign below     = drive.monitor_enable ? supply_low : junk;  // no valid level when off
    assign fuse_byte = fuse_in;  // loader holds the byte steady
endmodule
`default_nettype wire

// file: tb_top.sv
// Purpose: self-checking bench for the undervoltage detector control
// Assumes: short sample periods of 4 and 8 cycles
// Notes:   random values come from a fixed-seed xorshift
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import uvd_pkg::*;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic lock = 0, sleep_req = 0, halt = 0, supply_low = 0;
    logic awready, wready, bvalid, arready, rvalid, running, below, hold, irq;
    logic [5:0]  awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, v, seed = 32'hB65B012D;
    logic [1:0]  bresp, rresp, m;
    logic [7:0]  fuse = 8'h5A, fuse_byte;
    detector_drive_s drive;
    int n_fail = 0, num_checks = 0, cnt;
    always #10 aclk = ~aclk;
    undervoltage_detector_control #(.FAST_PERIOD(4), .SLOW_PERIOD(8)) u_dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .detector_fuse_byte(fuse_byte),
        .config_change_lock(lock), .deep_sleep(sleep_req), .debug_halt(halt), .detector_running(running),
        .supply_below_warning(below), .detector_drive(drive), .execution_hold(hold), .warning_irq(irq));
    analog_partner u_far (.aclk(aclk), .drive(drive), .supply_low(supply_low), .fuse_in(fuse),
        .running(running), .below(below), .fuse_byte(fuse_byte));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [31:0] mode_of(input logic [7:0] f);
        return {27'h0, f[3], f[5:4], f[7:6]};
    endfunction
    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // write: both items offered, each released when taken
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        logic aw_done;
        logic w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        while (!(aw_done && w_done)) begin
            @(posedge aclk);
            if (awready && !aw_done) begin
                awvalid <= 0;
                aw_done = 1'b1;
            end
            if (wready && !w_done) begin
                wvalid <= 0;
                w_done = 1'b1;
            end
        end
        do @(posedge aclk); while (!bvalid);
        m = bresp;
    endtask
    task automatic rd(input logic [5:0] a);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        do @(posedge aclk); while (!arready);
        arvalid <= 0;
        do @(posedge aclk); while (!rvalid);
        v = rdata;
        m = rresp;
    endtask
    task automatic rdc(input logic [5:0] a, input logic [31:0] exp);
        rd(a);
        chk(v, exp);
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        cyc(2);
        aresetn <= 1;
        cyc(1);
        rdc(6'h00, mode_of(fuse));
        rdc(6'h04, 32'h2);
        wr(6'h00, 8'h02);
        rdc(6'h00, 32'h15);
        lock <= 1;
        wr(6'h00, 8'h00);
        lock <= 0;
        rdc(6'h00, 32'h14);
        for (int i = 2; i < 8; i++) begin
            wr(6'(i * 4), 8'(rnd()));
            chk(32'(m), 32'(RESP_OKAY));
            rdc(6'(i * 4), 32'h0);
        end
        wr(6'h30, 8'h00);
        chk(32'(m), 32'(RESP_SLVERR));
        rd(6'h30);
        chk(32'(m), 32'(RESP_SLVERR));
        v = rnd() & 32'h3;
        wr(6'h20, v[7:0]);
        chk(32'(drive.margin_select), v);
        rdc(6'h20, v);
        wr(6'h24, 8'h01);
        cyc(3);
        supply_low <= 1;
        cyc(3);
        chk(32'(irq), 32'h1);
        rdc(6'h2C, 32'h1);
        halt <= 1;
        cyc(1);
        chk(32'(irq), 32'h0);
        halt <= 0;
        wr(6'h28, 8'h00);
        rdc(6'h28, 32'h1);
        wr(6'h28, 8'h01);
        rdc(6'h28, 32'h0);
        chk(32'(irq), 32'h0);
        for (int d = 0; d < 3; d++) begin
            wr(6'h24, {5'h0, 2'(d), 1'b1});
            wr(6'h28, 8'h01);
            supply_low <= 0;
            cyc(3);
            rdc(6'h28, 32'(d != 0));
            wr(6'h28, 8'h01);
            supply_low <= 1;
            cyc(3);
            rdc(6'h28, 32'(d != 1));
        end
        wr(6'h28, 8'h01);
        sleep_req <= 1;
        cyc(3);
        chk(32'(drive.detector_enable), 32'h0);
        chk(32'(drive.monitor_enable), 32'h0);
        supply_low <= 0;
        cyc(3);
        rdc(6'h28, 32'h0);
        sleep_req <= 0;
        cyc(3);
        chk(32'(drive.detector_enable), 32'h1);
        for (int k = 0; k < 6; k++) begin
            fuse <= (k == 0) ? 8'h20 : (k == 1) ? 8'h28 : (k == 2) ? 8'h30 : 8'(rnd());
            aresetn <= 0;
            cyc(2);
            aresetn <= 1;
            cyc(1);
            rdc(6'h00, mode_of(fuse));
            rdc(6'h04, 32'(fuse[2:0]));
            chk(32'(drive.threshold_code), 32'(fuse[2:0]));
            if (fuse[5:4] == MODE_WAKE_HOLD) begin
                sleep_req <= 1;
                cyc(2);
                sleep_req <= 0;
                cyc(2);
                chk(32'(hold), 32'h1);
                cyc(8);
                chk(32'(hold), 32'h0);
            end
            if (fuse[5:4] == MODE_SAMPLED) begin
                cnt = 0;
                do cyc(1); while (!drive.sample_strobe);
                do begin
                    cyc(1);
                    cnt++;
                end while (!drive.sample_strobe);
                chk(32'(cnt), fuse[3] ? 32'h8 : 32'h4);
            end
        end
        stop_test();
    end
    // watchdog against a hung handshake
    initial begin
        cyc(5000);
        n_fail++;
        stop_test();
    end
endmodule
`default_nettype wire
